// >>> design/dvm_voltage_transition_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dvm_voltage_transition_ctrl import dvm_pkg::*; #(
	parameter int LIN_W = 5,
	parameter int BUCK_SLOW_CYCLES = BUCK_SLOW_STEP_CYCLES,
	parameter logic [LIN_W-1:0] LIN_A_INIT = '0,
	parameter logic [LIN_W-1:0] LIN_B_INIT = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic [2:0] buckASlew,
	input wire logic [2:0] buckBSlew,
	input wire logic [LIN_W-1:0] linAPinLevel1,
	input wire logic [LIN_W-1:0] linAPinLevel2,
	input wire logic [LIN_W-1:0] linARegLevel1,
	input wire logic [LIN_W-1:0] linARegLevel2,
	input wire logic [LIN_W-1:0] linBLevel1,
	input wire logic [LIN_W-1:0] linBLevel2,
	input wire logic coreEnablePin_n,
	output logic [BUCK_CODE_W-1:0] buckALevel,
	output logic [BUCK_CODE_W-1:0] buckBLevel,
	output logic [LIN_W-1:0] linALevel,
	output logic [LIN_W-1:0] linBLevel,
	output logic buckAOn,
	output logic linAPinMode,
	output logic buckABusy,
	output logic buckBBusy,
	output logic linABusy,
	output logic linBBusy
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] ctrlA;
		logic [7:0] ctrlB;
		logic [BUCK_CODE_W-1:0] buckALvl1;
		logic [BUCK_CODE_W-1:0] buckALvl2;
		logic [BUCK_CODE_W-1:0] buckBLvl1;
		logic [BUCK_CODE_W-1:0] buckBLvl2;
		logic [2:0] pinSync;
		logic pinLevel;
		logic buckAOn;
		logic linAPinMode;
		logic [7:0] rdData;
	} state_type;

	state_type s_reg, s_next;

	logic buckAStart, buckBStart, linAStart, linBStart, buckALoad;
	logic [BUCK_CODE_W-1:0] buckATarget, buckBTarget;
	logic [LIN_W-1:0] linATarget, linBTarget;
	logic buckADone, buckBDone, linADone, linBDone;
	logic [STEP_CNT_W-1:0] buckASteps, buckBSteps;
	logic [7:0] wrA, wrB;
	logic wrCtrlA, wrCtrlB, pinFall;

	function automatic logic [STEP_CNT_W-1:0] buck_steps(input logic [2:0] code);
		int shift;
		int cyc;
		shift = 0;
		cyc = 0;
		if (code == SLEW_INSTANT) begin
			buck_steps = '0;
		end else begin
			// Undefined top code treated as the fastest defined rate
			shift = (code > SLEW_FASTEST) ? int'(SLEW_FASTEST) - 1 : int'(code) - 1;
			cyc = (BUCK_SLOW_CYCLES + (1 << shift) - 1) >> shift;
			buck_steps = STEP_CNT_W'(cyc);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and launch decode
	always_comb begin
		s_next = s_reg;
		wrCtrlA = regWrEn && regAddr == ADDR_CTRL_A;
		wrCtrlB = regWrEn && regAddr == ADDR_CTRL_B;
		wrA = wrCtrlA ? regWrData : s_reg.ctrlA;
		wrB = wrCtrlB ? regWrData : s_reg.ctrlB;

		// Pin: third stage agreeing with second counts as a change
		s_next.pinSync = {s_reg.pinSync[1:0], coreEnablePin_n};
		pinFall = 1'b0;
		if (s_reg.pinSync[2] == s_reg.pinSync[1]) begin
			s_next.pinLevel = s_reg.pinSync[2];
			pinFall = s_reg.pinLevel && !s_reg.pinSync[2];
		end

		// Level registers must be written ahead of the launch
		if (regWrEn) begin
			unique case (regAddr)
				ADDR_BUCK_A_LVL1: s_next.buckALvl1 = regWrData[BUCK_CODE_W-1:0];
				ADDR_BUCK_A_LVL2: s_next.buckALvl2 = regWrData[BUCK_CODE_W-1:0];
				ADDR_BUCK_B_LVL1: s_next.buckBLvl1 = regWrData[BUCK_CODE_W-1:0];
				ADDR_BUCK_B_LVL2: s_next.buckBLvl2 = regWrData[BUCK_CODE_W-1:0];
				default: begin
				end
			endcase
		end

		// Completion clears launch bits; a fresh write of 1 in that cycle wins
		s_next.ctrlA = wrA;
		s_next.ctrlB = wrB;
		if (buckADone) begin
			if (!(wrCtrlA && regWrData[A_BUCK_A_LAUNCH_1])) s_next.ctrlA[A_BUCK_A_LAUNCH_1] = 1'b0;
			if (!(wrCtrlB && regWrData[B_BUCK_A_LAUNCH_2])) s_next.ctrlB[B_BUCK_A_LAUNCH_2] = 1'b0;
		end
		if (buckBDone) begin
			if (!(wrCtrlA && regWrData[A_BUCK_B_LAUNCH_1])) s_next.ctrlA[A_BUCK_B_LAUNCH_1] = 1'b0;
			if (!(wrCtrlB && regWrData[B_BUCK_B_LAUNCH_2])) s_next.ctrlB[B_BUCK_B_LAUNCH_2] = 1'b0;
		end
		if (linBDone && !(wrCtrlA && regWrData[A_LIN_B_LAUNCH])) begin
			s_next.ctrlA[A_LIN_B_LAUNCH] = 1'b0;
		end
		if (linADone && !(wrCtrlB && regWrData[B_LIN_A_REG_LAUNCH])) begin
			s_next.ctrlB[B_LIN_A_REG_LAUNCH] = 1'b0;
		end

		// One write carries at most one start per supply, so both bits give one ramp
		buckAStart = (wrCtrlA && regWrData[A_BUCK_A_LAUNCH_1]) ||
			(wrCtrlB && regWrData[B_BUCK_A_LAUNCH_2]);
		buckBStart = (wrCtrlA && regWrData[A_BUCK_B_LAUNCH_1]) ||
			(wrCtrlB && regWrData[B_BUCK_B_LAUNCH_2]);
		linBStart = wrCtrlA && regWrData[A_LIN_B_LAUNCH];
		// Pin-path launch bits are stored but drive nothing
		linAStart = (wrCtrlB && regWrData[B_LIN_A_REG_LAUNCH]) || pinFall;

		buckATarget = (wrA[A_BUCK_A_SEL_1] || wrB[B_BUCK_A_SEL_2]) ?
			s_next.buckALvl2 : s_next.buckALvl1;
		buckBTarget = (wrA[A_BUCK_B_SEL_1] || wrB[B_BUCK_B_SEL_2]) ?
			s_next.buckBLvl2 : s_next.buckBLvl1;
		linBTarget = wrA[A_LIN_B_SEL] ? linBLevel2 : linBLevel1;

		if (pinFall) begin
			s_next.linAPinMode = 1'b1;
		end else if (wrCtrlB && regWrData[B_LIN_A_REG_LAUNCH]) begin
			s_next.linAPinMode = 1'b0;
		end
		if (pinFall) begin
			linATarget = wrB[B_LIN_A_PIN_SEL_1] ? linAPinLevel2 : linAPinLevel1;
		end else begin
			linATarget = wrB[B_LIN_A_REG_SEL] ? linARegLevel2 : linARegLevel1;
		end

		// Pin low: converter on at the default; pin high: off
		s_next.buckAOn = !s_next.pinLevel;
		buckALoad = pinFall;

		s_next.rdData = s_reg.rdData;
		if (regRdEn) begin
			unique case (regAddr)
				ADDR_CTRL_A: s_next.rdData = s_reg.ctrlA;
				ADDR_CTRL_B: s_next.rdData = s_reg.ctrlB;
				ADDR_BUCK_A_LVL1: s_next.rdData = {3'h0, s_reg.buckALvl1};
				ADDR_BUCK_A_LVL2: s_next.rdData = {3'h0, s_reg.buckALvl2};
				ADDR_BUCK_B_LVL1: s_next.rdData = {3'h0, s_reg.buckBLvl1};
				ADDR_BUCK_B_LVL2: s_next.rdData = {3'h0, s_reg.buckBLvl2};
				default: s_next.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{CTRL_RESET, CTRL_RESET, BUCK_LVL_RESET, BUCK_LVL_RESET,
				BUCK_LVL_RESET, BUCK_LVL_RESET, 3'h7, 1'b1, 1'b0, 1'b0, 8'h00};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ramp engines
	assign buckASteps = buck_steps(buckASlew);
	assign buckBSteps = buck_steps(buckBSlew);

	dvm_ramp #(.LEVEL_W(BUCK_CODE_W), .INIT_LEVEL(BUCK_DEFAULT_CODE)) buckARamp (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.load(buckALoad), .loadValue(BUCK_DEFAULT_CODE),
		.start(buckAStart), .target(buckATarget), .stepCycles(buckASteps),
		.level(buckALevel), .busy(buckABusy), .done(buckADone)
	);

	dvm_ramp #(.LEVEL_W(BUCK_CODE_W), .INIT_LEVEL(BUCK_DEFAULT_CODE)) buckBRamp (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.load(1'b0), .loadValue(BUCK_DEFAULT_CODE),
		.start(buckBStart), .target(buckBTarget), .stepCycles(buckBSteps),
		.level(buckBLevel), .busy(buckBBusy), .done(buckBDone)
	);

	dvm_ramp #(.LEVEL_W(LIN_W), .INIT_LEVEL(LIN_A_INIT)) linARamp (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.load(1'b0), .loadValue(LIN_A_INIT),
		.start(linAStart), .target(linATarget),
		.stepCycles(STEP_CNT_W'(LIN_STEP_CYCLES)),
		.level(linALevel), .busy(linABusy), .done(linADone)
	);

	dvm_ramp #(.LEVEL_W(LIN_W), .INIT_LEVEL(LIN_B_INIT)) linBRamp (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.load(1'b0), .loadValue(LIN_B_INIT),
		.start(linBStart), .target(linBTarget),
		.stepCycles(STEP_CNT_W'(LIN_STEP_CYCLES)),
		.level(linBLevel), .busy(linBBusy), .done(linBDone)
	);

	assign regRdData = s_reg.rdData;
	assign buckAOn = s_reg.buckAOn;
	assign linAPinMode = s_reg.linAPinMode;
endmodule
`default_nettype wire

// >>> include/dvm_pkg.sv
// What this block does
// - Select bits in both control registers pick each supply's next target level; A_LIN_A_PIN_SEL_2 is ignored.
// - Any launch bit but the two pin-path ones written to 1 starts a transition; otherwise level holds.
// - Internal logic clears a supply's launch bits, pin-path ones excepted, once its transition ends.
// - Control register A at 0x20 holds the documented eight bits B7 to B0.
// - Control register B at 0x21 holds the documented eight bits B7 to B0.
// - First converter: either launch starts; both selects 0 targets level 1, else 2.
// - Second converter: either launch starts; both selects 0 targets level 1, else 2.
// - Second linear launch starts it; its select picks level 1 or level 2.
// - Both pin-path launch bits of the first linear regulator are ignored.
// - First linear register launch starts it toward reg level 1 or 2 by select.
// - A falling core enable pin also starts a first linear regulator transition.
// - Under pin control the first linear regulator uses the pin level registers.
// - Core enable pin low runs first converter at 1.2 V; high switches it off.
// - On pin fall the first converter returns to its default level.
// - Converter codes are 5 bits, 0.725 V to 1.500 V in equal steps.
// - Transitions step gradually from present level to target; converter slew code 0 jumps straight there.
// - Linear regulators ramp at a fixed rate; converters use their slew setting.
package dvm_pkg;
	localparam logic [7:0] ADDR_CTRL_A = 8'h20;
	localparam logic [7:0] ADDR_CTRL_B = 8'h21;
	localparam logic [7:0] ADDR_BUCK_B_LVL1 = 8'h23;
	localparam logic [7:0] ADDR_BUCK_B_LVL2 = 8'h24;
	localparam logic [7:0] ADDR_BUCK_A_LVL1 = 8'h26;
	localparam logic [7:0] ADDR_BUCK_A_LVL2 = 8'h27;

	// Control register A bit positions
	localparam int A_LIN_B_SEL = 7;
	localparam int A_LIN_B_LAUNCH = 6;
	localparam int A_LIN_A_PIN_SEL_2 = 5;
	localparam int A_LIN_A_PIN_LAUNCH_2 = 4;
	localparam int A_BUCK_A_SEL_1 = 3;
	localparam int A_BUCK_A_LAUNCH_1 = 2;
	localparam int A_BUCK_B_SEL_1 = 1;
	localparam int A_BUCK_B_LAUNCH_1 = 0;
	// Control register B bit positions
	localparam int B_LIN_A_REG_SEL = 7;
	localparam int B_LIN_A_REG_LAUNCH = 6;
	localparam int B_LIN_A_PIN_SEL_1 = 5;
	localparam int B_LIN_A_PIN_LAUNCH_1 = 4;
	localparam int B_BUCK_A_SEL_2 = 3;
	localparam int B_BUCK_A_LAUNCH_2 = 2;
	localparam int B_BUCK_B_SEL_2 = 1;
	localparam int B_BUCK_B_LAUNCH_2 = 0;

	localparam int BUCK_CODE_W = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// 0.725 V + 19 * 25 mV = 1.200 V
	localparam logic [4:0] BUCK_DEFAULT_CODE = 5'h13;
	localparam logic [4:0] BUCK_LVL_RESET = 5'h00;

	localparam int CLK_PERIOD_NS = 40;
	localparam int STEP_UV = 25000;
	// Linear regulators: fixed 7 mV/us typical
	localparam int LIN_RATE_UV_PER_US = 7000;
	localparam int LIN_STEP_CYCLES = (STEP_UV * 1000 + LIN_RATE_UV_PER_US * CLK_PERIOD_NS - 1) /
		(LIN_RATE_UV_PER_US * CLK_PERIOD_NS);
	// Converters: slowest setting 0.11 mV/us, each code above up to 6 doubles the rate
	localparam int BUCK_SLOW_RATE_UV_PER_US = 110;
	localparam int BUCK_SLOW_STEP_CYCLES = (STEP_UV * 1000 +
		BUCK_SLOW_RATE_UV_PER_US * CLK_PERIOD_NS - 1) / (BUCK_SLOW_RATE_UV_PER_US * CLK_PERIOD_NS);
	localparam logic [2:0] SLEW_INSTANT = 3'h0;
	localparam logic [2:0] SLEW_FASTEST = 3'h6;
	localparam int STEP_CNT_W = 16;

	typedef enum logic {RAMP_IDLE = 1'b0, RAMP_RUN = 1'b1} ramp_state_type;
endpackage

// >>> design/dvm_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module dvm_ramp import dvm_pkg::*; #(
	parameter int LEVEL_W = 5,
	parameter logic [LEVEL_W-1:0] INIT_LEVEL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [LEVEL_W-1:0] loadValue,
	input wire logic start,
	input wire logic [LEVEL_W-1:0] target,
	input wire logic [STEP_CNT_W-1:0] stepCycles,
	output logic [LEVEL_W-1:0] level,
	output logic busy,
	output logic done
);
	typedef struct packed {
		ramp_state_type state;
		logic [LEVEL_W-1:0] level;
		logic [LEVEL_W-1:0] target;
		logic [STEP_CNT_W-1:0] count;
		logic done;
	} ramp_type;

	ramp_type r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (load) begin
			r_next.level = loadValue;
			r_next.target = loadValue;
			r_next.state = RAMP_IDLE;
		end
		if (start) begin
			// A new launch mid-ramp retargets from the present level
			r_next.target = target;
			r_next.count = '0;
			r_next.state = RAMP_RUN;
		end else begin
			unique case (r_reg.state)
				RAMP_IDLE: begin
				end
				RAMP_RUN: begin
					if (r_reg.level == r_reg.target) begin
						r_next.state = RAMP_IDLE;
						r_next.done = 1'b1;
					end else if (stepCycles == '0 || r_reg.count + 1'b1 >= stepCycles) begin
						r_next.count = '0;
						// One code per step; a zero step count jumps straight to target
						if (r_reg.level < r_reg.target) begin
							r_next.level = r_reg.level + 1'b1;
						end else begin
							r_next.level = r_reg.level - 1'b1;
						end
						if (stepCycles == '0) begin
							r_next.level = r_reg.target;
						end
					end else begin
						r_next.count = r_reg.count + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '{RAMP_IDLE, INIT_LEVEL, INIT_LEVEL, '0, 1'b0};
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign level = r_reg.level;
	assign busy = (r_reg.state == RAMP_RUN);
	assign done = r_reg.done;
endmodule
`default_nettype wire

// >>> tb/dvm_voltage_transition_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dvm_voltage_transition_ctrl_assertions import dvm_pkg::*; #(
	parameter int LIN_W = 5,
	parameter int BUCK_SLOW_CYCLES = 64
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic [LIN_W-1:0] linAPinLevel1,
	input wire logic [LIN_W-1:0] linAPinLevel2,
	input wire logic [LIN_W-1:0] linBLevel1,
	input wire logic [LIN_W-1:0] linBLevel2,
	input wire logic coreEnablePin_n,
	input wire logic [BUCK_CODE_W-1:0] buckALevel,
	input wire logic [LIN_W-1:0] linALevel,
	input wire logic [LIN_W-1:0] linBLevel,
	input wire logic buckAOn,
	input wire logic linAPinMode,
	input wire logic buckABusy,
	input wire logic buckBBusy,
	input wire logic linABusy,
	input wire logic linBBusy
);
	logic wrA;
	logic wrB;
	logic selB_reg;
	logic pinSel_reg;
	logic [2:0] highCnt_reg;
	logic [2:0] lowCnt_reg;
	assign wrA = ce && regWrEn && regAddr == ADDR_CTRL_A;
	assign wrB = ce && regWrEn && regAddr == ADDR_CTRL_B;
	// Shadow selects; pin counters saturate so a settled pin is unambiguous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			selB_reg <= 1'b0;
			pinSel_reg <= 1'b0;
			highCnt_reg <= 3'h0;
			lowCnt_reg <= 3'h0;
		end else if (ce) begin
			if (wrA) begin
				selB_reg <= regWrData[A_LIN_B_SEL];
			end
			if (wrB) begin
				pinSel_reg <= regWrData[B_LIN_A_PIN_SEL_1];
			end
			highCnt_reg <= !coreEnablePin_n ? 3'h0 : highCnt_reg + 3'(highCnt_reg != 3'h7);
			lowCnt_reg <= coreEnablePin_n ? 3'h0 : lowCnt_reg + 3'(lowCnt_reg != 3'h7);
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence launchA;
		(wrA && regWrData[A_BUCK_A_LAUNCH_1]) || (wrB && regWrData[B_BUCK_A_LAUNCH_2]);
	endsequence
	sequence launchB;
		(wrA && regWrData[A_BUCK_B_LAUNCH_1]) || (wrB && regWrData[B_BUCK_B_LAUNCH_2]);
	endsequence
	sequence pinFall;
		$rose(buckAOn);
	endsequence
	AST_BUCK_A_GO: assert property (launchA |=> buckABusy)
		else $error("first converter launch ignored");
	AST_BUCK_B_GO: assert property (launchB |=> buckBBusy)
		else $error("second converter launch ignored");
	AST_LIN_B_GO: assert property (wrA && regWrData[A_LIN_B_LAUNCH] |=> linBBusy)
		else $error("second linear launch ignored");
	AST_LIN_A_GO: assert property (wrB && regWrData[B_LIN_A_REG_LAUNCH] |=> linABusy)
		else $error("first linear launch ignored");
	AST_LIN_A_PIN_BITS: assert property (wrB && !regWrData[B_LIN_A_REG_LAUNCH] &&
		!linABusy && highCnt_reg == 3'h7 |=> !linABusy)
		else $error("pin path launch started a ramp");
	AST_LIN_B_TARGET: assert property ($fell(linBBusy) |->
		linBLevel == (selB_reg ? linBLevel2 : linBLevel1))
		else $error("second linear ended off target");
	AST_PIN_TARGET: assert property ($fell(linABusy) && linAPinMode |->
		linALevel == (pinSel_reg ? linAPinLevel2 : linAPinLevel1))
		else $error("pin ramp ended off target");
	AST_LIN_STEP: assert property ($changed(linBLevel) |->
		linBLevel == $past(linBLevel) + 1'b1 || linBLevel == $past(linBLevel) - 1'b1)
		else $error("linear level jumped");
	AST_LIN_RATE: assert property ($changed(linBLevel) |=> $stable(linBLevel)[*8])
		else $error("linear level stepped too fast");
	AST_PIN_ON: assert property (lowCnt_reg == 3'h7 |-> buckAOn)
		else $error("converter off with pin low");
	AST_PIN_OFF: assert property (highCnt_reg == 3'h7 |-> !buckAOn)
		else $error("converter on with pin high");
	AST_PIN_RELOAD: assert property (pinFall |-> buckALevel == BUCK_DEFAULT_CODE)
		else $error("converter not back at default");
	AST_PIN_LIN_A: assert property (pinFall |-> ##[0:2] linABusy && linAPinMode)
		else $error("pin fall did not start linear ramp");
endmodule
bind dvm_voltage_transition_ctrl dvm_voltage_transition_ctrl_assertions #(.LIN_W(LIN_W),
	.BUCK_SLOW_CYCLES(BUCK_SLOW_CYCLES)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
	.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
	.linAPinLevel1(linAPinLevel1), .linAPinLevel2(linAPinLevel2),
	.linBLevel1(linBLevel1), .linBLevel2(linBLevel2), .coreEnablePin_n(coreEnablePin_n),
	.buckALevel(buckALevel), .linALevel(linALevel), .linBLevel(linBLevel),
	.buckAOn(buckAOn), .linAPinMode(linAPinMode), .buckABusy(buckABusy),
	.buckBBusy(buckBBusy), .linABusy(linABusy), .linBBusy(linBBusy));
`default_nettype wire

// >>> tb/dvm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dvm_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn
);
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Callers send level before launch; released lines show inverse data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk_sys);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk_sys);
		regRdEn = 1'b0;
		regAddr = ~a;
		@(negedge clk_sys);
		d = regRdData;
	endtask
endmodule
`default_nettype wire

// >>> tb/dvm_voltage_transition_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dvm_voltage_transition_ctrl_tb import dvm_pkg::*;;
	logic clk_sys, rst_n, ce, regWrEn, regRdEn, coreEnablePin_n;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [2:0] buckASlew, buckBSlew;
	logic [4:0] pinL1, pinL2, regL1, regL2, linBL1, linBL2;
	logic [4:0] buckALevel, buckBLevel, linALevel, linBLevel;
	logic buckAOn, linAPinMode, buckABusy, buckBBusy, linABusy, linBBusy;
	int errors, checks;
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	dvm_voltage_transition_ctrl #(.BUCK_SLOW_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.ce(ce), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData), .buckASlew(buckASlew), .buckBSlew(buckBSlew),
		.linAPinLevel1(pinL1), .linAPinLevel2(pinL2), .linARegLevel1(regL1),
		.linARegLevel2(regL2), .linBLevel1(linBL1), .linBLevel2(linBL2),
		.coreEnablePin_n(coreEnablePin_n), .buckALevel(buckALevel), .buckBLevel(buckBLevel),
		.linALevel(linALevel), .linBLevel(linBLevel), .buckAOn(buckAOn),
		.linAPinMode(linAPinMode), .buckABusy(buckABusy), .buckBBusy(buckBBusy),
		.linABusy(linABusy), .linBBusy(linBBusy));
	dvm_host_model host_u (.clk_sys(clk_sys), .regRdData(regRdData), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_u.rd(a, v);
		chk(v, exp);
	endtask
	function automatic logic sigOf(input int k);
		case (k)
			0: return buckABusy;
			1: return buckBBusy;
			2: return linABusy;
			3: return linBBusy;
			default: return buckAOn;
		endcase
	endfunction
	// Slow linear steps need a generous bound
	task automatic waitVal(input int k, input logic v);
		int n;
		n = 0;
		while (sigOf(k) !== v) begin
			@(negedge clk_sys);
			n++;
			if (n > 3000) begin
				$display("wrong value at %0t ns: got %h expected %h", $time, sigOf(k), v);
				errors++;
				finish_test();
			end
		end
	endtask
	task automatic runBuck(input int b, input int i);
		logic [4:0] l1, l2, e;
		logic [7:0] base, ca, cb;
		int s;
		s = (b == 0) ? A_BUCK_A_SEL_1 : A_BUCK_B_SEL_1;
		base = (b == 0) ? ADDR_BUCK_A_LVL1 : ADDR_BUCK_B_LVL1;
		l1 = 5'h08;
		l2 = i[0] ? 5'h1e - 5'(i) : 5'h04 + 5'(i);
		e = (i == 0) ? l1 : l2;
		ca = 8'(i[1]) << s | 8'(i != 1) << (s - 1);
		cb = 8'(i[0]) << s | 8'(i >= 1) << (s - 1);
		// Odd codes walk the slew decode, 7 included
		buckASlew = (b == 0) ? 3'(2 * i + 1) : buckASlew;
		host_u.wr(base, 8'(l1));
		host_u.wr(base + 8'h01, 8'(l2));
		host_u.wr(ADDR_CTRL_B, cb);
		host_u.wr(ADDR_CTRL_A, ca);
		if (b == 0) begin
			rdchk(ADDR_CTRL_A, ca);
			rdchk(ADDR_CTRL_B, cb);
		end
		waitVal(b, 1'b0);
		chk(8'(b == 0 ? buckALevel : buckBLevel), 8'(e));
		rdchk(ADDR_CTRL_A, ca & ~(8'h01 << (s - 1)));
		rdchk(ADDR_CTRL_B, cb & ~(8'h01 << (s - 1)));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		checks = 0;
		clk_sys = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		coreEnablePin_n = 1'b1;
		buckASlew = 3'h1;
		buckBSlew = SLEW_INSTANT;
		pinL1 = 5'h06;
		pinL2 = 5'h0b;
		regL1 = 5'h04;
		regL2 = 5'h02;
		linBL1 = 5'h03;
		linBL2 = 5'h09;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		rdchk(ADDR_CTRL_A, CTRL_RESET);
		rdchk(ADDR_CTRL_B, CTRL_RESET);
		rdchk(8'h22, 8'h00);
		chk(8'(buckAOn), 8'h00);
		host_u.wr(ADDR_BUCK_A_LVL1, 8'hff);
		rdchk(ADDR_BUCK_A_LVL1, 8'h1f);
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 4; i++) begin
				runBuck(b, i);
			end
		end
		host_u.wr(ADDR_CTRL_B, 8'h30);
		host_u.wr(ADDR_CTRL_A, 8'h30);
		repeat (20) @(negedge clk_sys);
		chk(8'({linABusy, linALevel}), 8'h00);
		rdchk(ADDR_CTRL_B, 8'h30);
		host_u.wr(ADDR_CTRL_B, 8'hc0);
		waitVal(2, 1'b0);
		chk(8'(linALevel), 8'h02);
		rdchk(ADDR_CTRL_B, 8'h80);
		for (int k = 1; k >= 0; k--) begin
			host_u.wr(ADDR_CTRL_A, 8'(k) << A_LIN_B_SEL | 8'h40);
			waitVal(3, 1'b0);
			chk(8'(linBLevel), k ? 8'h09 : 8'h03);
			rdchk(ADDR_CTRL_A, 8'(k) << A_LIN_B_SEL);
		end
		coreEnablePin_n = 1'b0;
		waitVal(4, 1'b1);
		chk(8'({buckAOn, buckALevel}), 8'h33);
		@(negedge clk_sys);
		chk(8'({linAPinMode, linABusy}), 8'h03);
		// Enable low freezes the ramp well inside its first step
		ce = 1'b0;
		repeat (200) @(negedge clk_sys);
		chk(8'({linABusy, linALevel}), 8'h22);
		ce = 1'b1;
		waitVal(2, 1'b0);
		chk(8'(linALevel), 8'h06);
		coreEnablePin_n = 1'b1;
		waitVal(4, 1'b0);
		// Mid-run reset with the pin high must not fake a pin fall
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		rdchk(ADDR_CTRL_B, CTRL_RESET);
		chk(8'({buckAOn, linAPinMode, buckALevel}), 8'(BUCK_DEFAULT_CODE));
		chk(8'({linABusy, linALevel}), 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
